// ==== rtl/aoloc_pkg.sv ====
// constants and types shared by the offset loop and output control block
package aoloc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CLAMP  = 8'h04;
	localparam logic [7:0] OFS_LOOP   = 8'h08;
	localparam logic [7:0] OFS_ANALOG = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_DAC    = 8'h14;

	// control register bit positions
	localparam int CTRL_WAIT_BIT   = 0;
	localparam int CTRL_TEST_BIT   = 1;
	localparam int CTRL_GRAY_BIT   = 2;
	localparam int CTRL_LOINV_BIT  = 3;
	localparam int CTRL_TOPINV_BIT = 4;
	localparam int CTRL_PBPOL_BIT = 5;
	localparam logic [5:0] CTRL_RST = 6'h00;

	// clamp code field and its legal range
	localparam int         CLAMP_POS = 0;
	localparam logic [6:0] CLAMP_MIN = 7'h0e;
	localparam logic [6:0] CLAMP_MAX = 7'h4c;
	localparam logic [6:0] CLAMP_RST = 7'h20;

	// loop register fields
	localparam int         NSEL_POS = 0;
	localparam int         HSEL_POS = 2;
	localparam int         GAIN_POS = 8;
	localparam logic [1:0] NSEL_RST = 2'h0;
	localparam logic [1:0] HSEL_RST = 2'h0;
	localparam logic [7:0] GAIN_RST = 8'h00;

	// analog setting register fields
	localparam int         RC_POS    = 0;
	localparam int         BW_POS    = 4;
	localparam int         RPWR_POS  = 6;
	localparam logic [3:0] RC_RST    = 4'h0;
	localparam logic [1:0] BW_RST    = 2'h1;
	localparam logic       RPWR_RST  = 1'b0;

	// status register fields
	localparam int ST_BLACK_POS = 0;
	localparam int ST_FAST_POS  = 16;
	localparam int ST_REL_POS   = 17;
	localparam int ST_PB_POS    = 18;

	// black window positions counted in conversion clocks, and loop figures
	localparam logic [3:0]  OB_FIRST     = 4'h5;
	localparam logic [3:0]  OB_LAST      = 4'hc;
	localparam logic [3:0]  OB_IDLE      = 4'hd;
	localparam int          OB_AVG_SHIFT = 3;
	localparam logic [10:0] ERR_THRESH   = 11'h020;
	localparam logic [3:0]  LEADIN_SHIFT = 4'h2;
	localparam logic [15:0] DAC_RST      = 16'h0000;
	localparam logic [19:0] DAC_MAX      = 20'h07fff;
	localparam logic [19:0] DAC_MIN      = 20'hf8000;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// offset loop states, gray coded along normal -> fast -> release
	typedef enum logic [1:0] {
		LP_NORMAL  = 2'h0,
		LP_FAST    = 2'h1,
		LP_RELEASE = 2'h3
	} aoloc_loop_t;

endpackage

// ==== rtl/aoloc_out_fmt.sv ====
// output word formatter: code format, inversion, clamp and test substitution
`timescale 1ns/1ps
module aoloc_out_fmt
	import aoloc_pkg::*;
(
	// conversion result
	input  wire logic [9:0] step,
	// format controls
	input  wire logic       test_mode_select,
	input  wire logic       gray_code_select,
	input  wire logic       lower_bits_invert,
	input  wire logic       top_bit_invert,
	input  wire logic       pb_active,
	input  wire logic [6:0] clamp_code,
	// formatted word
	output logic      [9:0] word
);

	logic [9:0] coded;

	always_comb
	begin
		coded = step;
		if (gray_code_select)
		begin
			coded = step ^ {1'b0, step[9:1]};
		end
		coded = coded ^ {top_bit_invert, {9{lower_bits_invert}}};
		// test mode passes raw step, preblank ignored
		if (test_mode_select)
		begin
			word = step;
		end
		else if (pb_active)
		begin
			word = {3'h0, clamp_code};
		end
		else
		begin
			word = coded;
		end
	end

endmodule

// ==== rtl/aoloc_top.sv ====
// offset feedback loop and output control with an axi4-lite register file
`timescale 1ns/1ps
// Overview of operation
// - drive feedback so black settles at target
// - error from black window codes steers dac
// - one reference pulse period is one line
// - gain change enters fast lead-in state
// - lead-in factor selector gives 4/8/16/32
// - stay fast while error above 32
// - release after 1/2/4/8 lines within threshold
// - preblank isolates input, outputs clamp code
// - polarity bit low makes preblank active low
// - standby or disable pin floats outputs
// - disable, preblank pins; others from registers
// - binary output with top/lower inversion
// - gray select outputs reflected gray code
// - preblank overrides inversion, forces clamp code
// - test bit gives test mode, ignores preblank
// - four-bit black sample rc select field
// - black window is clocks five to twelve
// - output word updates on conversion clock rise
module aoloc_top
	import aoloc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// pulses and pins from the signal processor
	input  wire logic        conversion_clock,
	input  wire logic        black_ref_pulse,
	input  wire logic        preblank_input,
	input  wire logic        output_disable_pin,
	// raw converter step
	input  wire logic [9:0]  conv_step,
	// digital output pins
	output logic [9:0]       conversion_output,
	output logic             conversion_output_oe_n,
	// analog front end controls
	output logic [15:0]      offset_dac_code,
	output logic             sample_isolate,
	output logic             low_power_wait,
	output logic [3:0]       black_sample_rc_select,
	output logic [1:0]       hold_buffer_bw_select,
	output logic             reduced_power_bit,
	output logic [7:0]       late_gain_amp
);

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [5:0]  ctrl;
		logic [6:0]  clamp;
		logic [1:0]  nsel;
		logic [1:0]  hsel;
		logic [7:0]  gain;
		logic [3:0]  rc_sel;
		logic [1:0]  bw_sel;
		logic        rpwr;
		logic        conv_prev;
		logic        ref_prev;
		logic [3:0]  ob_cnt;
		logic [12:0] ob_sum;
		logic [9:0]  black;
		logic [15:0] dac;
		aoloc_loop_t lstate;
		logic [2:0]  rel_cnt;
		logic [9:0]  out_word;
		logic        oe_n;
		logic        isolate;
	} aoloc_state_t;

	aoloc_state_t s_r;
	aoloc_state_t s_nxt;
	logic [9:0]   fmt_word;
	logic         pb_act;

	// byte-lane merge of a write into a register image
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
			begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	assign pb_act = s_r.ctrl[CTRL_PBPOL_BIT] ? preblank_input : ~preblank_input;

	aoloc_out_fmt u_fmt (
		.step              (conv_step),
		.test_mode_select  (s_r.ctrl[CTRL_TEST_BIT]),
		.gray_code_select  (s_r.ctrl[CTRL_GRAY_BIT]),
		.lower_bits_invert (s_r.ctrl[CTRL_LOINV_BIT]),
		.top_bit_invert    (s_r.ctrl[CTRL_TOPINV_BIT]),
		.pb_active         (pb_act),
		.clamp_code        (s_r.clamp),
		.word              (fmt_word)
	);

	always_comb
	begin
		logic               conv_rise;
		logic               ref_rise;
		logic               do_wr;
		logic               gain_chg;
		logic [3:0]         cnt_inc;
		logic [9:0]         avg;
		logic signed [10:0] err;
		logic [10:0]        err_abs;
		logic [3:0]         shamt;
		logic signed [19:0] step_sh;
		logic signed [19:0] dac_sum;
		logic [31:0]        cur;
		logic [31:0]        wval;
		logic [31:0]        rval;
		logic [6:0]         cl;
		conv_rise = 1'b0;
		ref_rise  = 1'b0;
		do_wr     = 1'b0;
		gain_chg  = 1'b0;
		cnt_inc   = 4'h0;
		avg       = 10'h000;
		err       = 11'h000;
		err_abs   = 11'h000;
		shamt     = 4'h0;
		step_sh   = 20'h00000;
		dac_sum   = 20'h00000;
		cur       = 32'h00000000;
		wval      = 32'h00000000;
		rval      = 32'h00000000;
		cl        = 7'h00;
		s_nxt     = s_r;

		// write channel capture
		if (s_axi_awvalid && s_r.awready)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready)
		begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
		begin
			do_wr        = 1'b1;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = RESP_OKAY;
			case (s_r.awaddr)
				OFS_CTRL:
				begin
					cur = {26'h0, s_r.ctrl};
				end
				OFS_CLAMP:
				begin
					cur = {25'h0, s_r.clamp};
				end
				OFS_LOOP:
				begin
					cur = {16'h0, s_r.gain, 4'h0, s_r.hsel, s_r.nsel};
				end
				OFS_ANALOG:
				begin
					cur = {25'h0, s_r.rpwr, s_r.bw_sel, s_r.rc_sel};
				end
				OFS_STATUS, OFS_DAC:
				begin
					cur = 32'h00000000;
				end
				default:
				begin
					do_wr       = 1'b0;
					s_nxt.bresp = RESP_SLVERR;
				end
			endcase
			wval = wmerge(cur, s_r.wdata, s_r.wstrb);
		end
		if (do_wr)
		begin
			case (s_r.awaddr)
				OFS_CTRL:
				begin
					// standby, test and inversion bits from register
					s_nxt.ctrl = wval[5:0];
				end
				OFS_CLAMP:
				begin
					// clamp code kept inside its range
					cl = wval[CLAMP_POS +: 7];
					if (cl < CLAMP_MIN)
					begin
						cl = CLAMP_MIN;
					end
					else if (cl > CLAMP_MAX)
					begin
						cl = CLAMP_MAX;
					end
					s_nxt.clamp = cl;
				end
				OFS_LOOP:
				begin
					s_nxt.nsel = wval[NSEL_POS +: 2];
					s_nxt.hsel = wval[HSEL_POS +: 2];
					s_nxt.gain = wval[GAIN_POS +: 8];
					gain_chg   = (wval[GAIN_POS +: 8] != s_r.gain);
				end
				OFS_ANALOG:
				begin
					s_nxt.rc_sel = wval[RC_POS +: 4];
					s_nxt.bw_sel = wval[BW_POS +: 2];
					s_nxt.rpwr   = wval[RPWR_POS];
				end
				default:
				begin
					s_nxt.rpwr = s_r.rpwr;
				end
			endcase
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

		// read channel
		if (s_r.rvalid && s_axi_rready)
		begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = RESP_OKAY;
			case (s_axi_araddr)
				OFS_CTRL:
				begin
					rval = {26'h0, s_r.ctrl};
				end
				OFS_CLAMP:
				begin
					rval = {25'h0, s_r.clamp};
				end
				OFS_LOOP:
				begin
					rval = {16'h0, s_r.gain, 4'h0, s_r.hsel, s_r.nsel};
				end
				OFS_ANALOG:
				begin
					rval = {25'h0, s_r.rpwr, s_r.bw_sel, s_r.rc_sel};
				end
				OFS_STATUS:
				begin
					rval[ST_BLACK_POS +: 10] = s_r.black;
					rval[ST_FAST_POS]        = (s_r.lstate == LP_FAST);
					rval[ST_REL_POS]         = (s_r.lstate == LP_RELEASE);
					rval[ST_PB_POS]          = pb_act;
				end
				OFS_DAC:
				begin
					rval = {16'h0, s_r.dac};
				end
				default:
				begin
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
			s_nxt.rdata = rval;
		end
		s_nxt.arready = !s_nxt.rvalid;

		// edge detection of the synchronous pulse inputs
		s_nxt.conv_prev = conversion_clock;
		s_nxt.ref_prev  = black_ref_pulse;
		conv_rise       = conversion_clock && !s_r.conv_prev;
		ref_rise        = black_ref_pulse && !s_r.ref_prev;

		if (ref_rise)
		begin
			s_nxt.ob_cnt = 4'h0;
			s_nxt.ob_sum = 13'h0000;
		end
		else if (conv_rise && s_r.ob_cnt != OB_IDLE)
		begin
			cnt_inc      = s_r.ob_cnt + 4'h1;
			s_nxt.ob_cnt = cnt_inc;
			if (cnt_inc >= OB_FIRST)
			begin
				s_nxt.ob_sum = s_r.ob_sum + {3'h0, conv_step};
			end
			// one loop update per reference pulse
			if (cnt_inc == OB_LAST)
			begin
				avg         = s_nxt.ob_sum[OB_AVG_SHIFT +: 10];
				s_nxt.black = avg;
				// signed and absolute error against target
				err         = $signed({1'b0, avg}) - $signed({4'h0, s_r.clamp});
				err_abs     = err[10] ? 11'(-err) : err;
				shamt       = (s_r.lstate == LP_NORMAL) ? 4'h0 :
					LEADIN_SHIFT + {2'h0, s_r.nsel};
				step_sh     = 20'(err) <<< shamt;
				dac_sum     = $signed({{4{s_r.dac[15]}}, s_r.dac}) - step_sh;
				if (dac_sum > $signed(DAC_MAX))
				begin
					dac_sum = $signed(DAC_MAX);
				end
				else if (dac_sum < $signed(DAC_MIN))
				begin
					dac_sum = $signed(DAC_MIN);
				end
				s_nxt.dac = dac_sum[15:0];
				case (s_r.lstate)
					LP_FAST:
					begin
						if (err_abs <= ERR_THRESH)
						begin
							s_nxt.lstate  = LP_RELEASE;
							s_nxt.rel_cnt = 3'h0;
						end
					end
					LP_RELEASE:
					begin
						// release after the selected line count
						if (err_abs > ERR_THRESH)
						begin
							s_nxt.lstate = LP_FAST;
						end
						else if ({1'b0, s_r.rel_cnt} + 4'h1 == (4'h1 << s_r.hsel))
						begin
							s_nxt.lstate = LP_NORMAL;
						end
						else
						begin
							s_nxt.rel_cnt = s_r.rel_cnt + 3'h1;
						end
					end
					default:
					begin
						s_nxt.lstate = LP_NORMAL;
					end
				endcase
			end
		end
		if (gain_chg)
		begin
			s_nxt.lstate  = LP_FAST;
			s_nxt.rel_cnt = 3'h0;
		end

		// output word on conversion clock rise
		if (conv_rise)
		begin
			s_nxt.out_word = fmt_word;
		end
		// standby or disable pin floats outputs
		s_nxt.oe_n    = s_r.ctrl[CTRL_WAIT_BIT] || output_disable_pin;
		s_nxt.isolate = pb_act && !s_r.ctrl[CTRL_TEST_BIT];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r           <= '0;
			s_r.ctrl      <= CTRL_RST;
			s_r.clamp     <= CLAMP_RST;
			s_r.nsel      <= NSEL_RST;
			s_r.hsel      <= HSEL_RST;
			s_r.gain      <= GAIN_RST;
			s_r.rc_sel    <= RC_RST;
			s_r.bw_sel    <= BW_RST;
			s_r.rpwr      <= RPWR_RST;
			s_r.ob_cnt    <= OB_IDLE;
			s_r.dac       <= DAC_RST;
			s_r.lstate    <= LP_NORMAL;
			s_r.oe_n      <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready          = s_r.awready;
	assign s_axi_wready           = s_r.wready;
	assign s_axi_bresp            = s_r.bresp;
	assign s_axi_bvalid           = s_r.bvalid;
	assign s_axi_arready          = s_r.arready;
	assign s_axi_rdata            = s_r.rdata;
	assign s_axi_rresp            = s_r.rresp;
	assign s_axi_rvalid           = s_r.rvalid;
	assign conversion_output      = s_r.out_word;
	assign conversion_output_oe_n = s_r.oe_n;
	assign offset_dac_code        = s_r.dac;
	assign sample_isolate         = s_r.isolate;
	assign low_power_wait         = s_r.ctrl[CTRL_WAIT_BIT];
	assign black_sample_rc_select = s_r.rc_sel;
	assign hold_buffer_bw_select  = s_r.bw_sel;
	assign reduced_power_bit      = s_r.rpwr;
	assign late_gain_amp          = s_r.gain;

endmodule

// ==== verification/aoloc_top_asserts.sv ====
// concurrent checks on the ports of the offset loop and output control top
`timescale 1ns/1ps
module aoloc_top_asserts
	import aoloc_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// pins and loop outputs
	input wire logic        conversion_clock,
	input wire logic        black_ref_pulse,
	input wire logic        output_disable_pin,
	input wire logic [9:0]  conversion_output,
	input wire logic        conversion_output_oe_n,
	input wire logic [15:0] offset_dac_code,
	input wire logic        sample_isolate,
	input wire logic        low_power_wait
);
	logic       cp_r;
	logic       bp_r;
	logic [3:0] cnt_r;
	logic       rise;
	assign rise = conversion_clock && !cp_r;
	// conversion rises since the last reference pulse
	always_ff @(posedge aclk)
	begin
		cp_r <= conversion_clock;
		bp_r <= black_ref_pulse;
		if (!aresetn)
			cnt_r <= 4'hd;
		else if (black_ref_pulse && !bp_r)
			cnt_r <= 4'h0;
		else if (rise && cnt_r < 4'hd)
			cnt_r <= cnt_r + 4'h1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_raised;
		##[1:2] s_axi_bvalid;
	endsequence
	chk_wr_answer:
	assert property (wr_taken |-> b_raised) else $error("write answer missing");
	chk_aw_block:
	assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
		else $error("write address taken twice");
	chk_rd_answer:
	assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read answer missing");
	chk_pin_float:
	assert property (output_disable_pin |=> conversion_output_oe_n)
		else $error("outputs driven while disabled");
	chk_wait_float:
	assert property (low_power_wait |=> conversion_output_oe_n)
		else $error("outputs driven in standby");
	chk_word_hold:
	assert property (!rise |=> $stable(conversion_output))
		else $error("word changed without conversion rise");
	chk_clamp_range:
	assert property (rise ##1 sample_isolate |->
		conversion_output >= 10'h00e && conversion_output <= 10'h04c)
		else $error("preblank word is not a clamp code");
	chk_dac_stable:
	assert property (!rise |=> $stable(offset_dac_code))
		else $error("dac moved without conversion rise");
	chk_dac_twelve:
	assert property ($changed(offset_dac_code) |-> cnt_r == 4'hc)
		else $error("dac moved away from the twelfth rise");
endmodule
bind aoloc_top aoloc_top_asserts u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .conversion_clock(conversion_clock),
	.black_ref_pulse(black_ref_pulse), .output_disable_pin(output_disable_pin),
	.conversion_output(conversion_output),
	.conversion_output_oe_n(conversion_output_oe_n),
	.offset_dac_code(offset_dac_code), .sample_isolate(sample_isolate),
	.low_power_wait(low_power_wait)
);

// ==== verification/aoloc_dsp_model.sv ====
// signal processor model: conversion clock, line pulses and control pins
`timescale 1ns/1ps
module aoloc_dsp_model
(
	// clock
	input  wire logic aclk,
	// pins toward the block
	output logic       conversion_clock,
	output logic       black_ref_pulse,
	output logic       preblank_input,
	output logic       output_disable_pin,
	output logic [9:0] conv_step
);
	initial
	begin
		conversion_clock = 1'b0;
		black_ref_pulse = 1'b0;
		preblank_input = 1'b1;
		output_disable_pin = 1'b0;
		conv_step = 10'h000;
	end
	// one conversion, step shown inverted while the clock is low
	task conv(input logic [9:0] s);
		@(posedge aclk);
		conversion_clock <= 1'b1;
		conv_step <= s;
		repeat (2) @(posedge aclk);
		conversion_clock <= 1'b0;
		conv_step <= ~s;
		@(posedge aclk);
	endtask
	task line(input logic [9:0] v);
		int i;
		@(posedge aclk);
		black_ref_pulse <= 1'b1;
		repeat (2) @(posedge aclk);
		black_ref_pulse <= 1'b0;
		for (i = 0; i < 13; i++)
			conv(v);
	endtask
	task pins(input logic pb, input logic dis);
		@(posedge aclk);
		preblank_input <= pb;
		output_disable_pin <= dis;
	endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the offset loop and output control top
`timescale 1ns/1ps
module tb
	import aoloc_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rdat;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, oe_n, iso, lpw, rpw, cck, bpl, pb, dis;
	logic [1:0] bresp, rresp, resp, bw;
	logic [9:0] cout, step;
	logic [15:0] dac;
	logic [3:0] rc;
	logic [7:0] gain;
	int fail_count = 0, samples_checked = 0;
	always #2.5 aclk = ~aclk;
	aoloc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .conversion_clock(cck), .black_ref_pulse(bpl),
		.preblank_input(pb), .output_disable_pin(dis), .conv_step(step),
		.conversion_output(cout), .conversion_output_oe_n(oe_n),
		.offset_dac_code(dac), .sample_isolate(iso), .low_power_wait(lpw),
		.black_sample_rc_select(rc), .hold_buffer_bw_select(bw),
		.reduced_power_bit(rpw), .late_gain_amp(gain));
	aoloc_dsp_model u_dsp (.aclk(aclk), .conversion_clock(cck), .black_ref_pulse(bpl),
		.preblank_input(pb), .output_disable_pin(dis), .conv_step(step));
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	function automatic logic [9:0] fmt(logic [9:0] s, logic [5:0] c);
		logic [9:0] g;
		g = c[2] ? s ^ (s >> 1) : s;
		return c[1] ? s : g ^ {c[4], {9{c[3]}}};
	endfunction
	task t_regs;
		cmp(32'(oe_n), 32'h0);
		rd(OFS_CTRL);
		cmp(rdat, 32'h0);
		rd(OFS_CLAMP);
		cmp(rdat, 32'h20);
		rd(OFS_ANALOG);
		cmp(32'({rpw, bw, rc}), 32'h10);
		wr(OFS_ANALOG, 32'h2f);
		rd(OFS_ANALOG);
		cmp(rdat, 32'h2f);
		cmp(32'({rpw, bw, rc}), 32'h2f);
		wr(8'h20, 32'h1);
		cmp(32'(resp), 32'(RESP_SLVERR));
		rd(8'h20);
		cmp({rdat[29:0], resp}, 32'(RESP_SLVERR));
		wr(OFS_STATUS, 32'hffff);
		cmp(32'(resp), 32'(RESP_OKAY));
		rd(OFS_DAC);
		cmp(rdat, 32'h0);
	endtask
	task t_format;
		int m, i;
		logic [9:0] s;
		for (m = 0; m < 8; m++)
		begin
			wr(OFS_CTRL, 32'(m << 2));
			for (i = 0; i < 3; i++)
			begin
				s = (i == 0) ? 10'h003 : (i == 1) ? 10'h1ff : 10'h200;
				u_dsp.conv(s);
				cmp(32'(cout), 32'(fmt(s, 6'(m << 2))));
			end
		end
	endtask
	task t_preblank;
		wr(OFS_CLAMP, 32'h5);
		rd(OFS_CLAMP);
		cmp(rdat, 32'h0e);
		wr(OFS_CLAMP, 32'h7f);
		rd(OFS_CLAMP);
		cmp(rdat, 32'h4c);
		wr(OFS_CTRL, 32'h1c);
		u_dsp.pins(1'b0, 1'b0);
		u_dsp.conv(10'h155);
		cmp(32'({iso, cout}), 32'h44c);
		wr(OFS_CTRL, 32'h3c);
		u_dsp.conv(10'h155);
		cmp(32'({iso, cout}), 32'(fmt(10'h155, 6'h3c)));
		wr(OFS_CTRL, 32'h22);
		u_dsp.pins(1'b1, 1'b0);
		u_dsp.conv(10'h155);
		cmp(32'({iso, cout}), 32'h155);
		wr(OFS_CTRL, 32'h0);
	endtask
	task t_float;
		u_dsp.pins(1'b1, 1'b1);
		repeat (2) @(posedge aclk);
		cmp(32'(oe_n), 32'h1);
		u_dsp.pins(1'b1, 1'b0);
		repeat (2) @(posedge aclk);
		cmp(32'(oe_n), 32'h0);
		wr(OFS_CTRL, 32'h1);
		repeat (2) @(posedge aclk);
		cmp(32'({lpw, oe_n}), 32'h3);
		wr(OFS_CTRL, 32'h0);
		repeat (2) @(posedge aclk);
		cmp(32'(oe_n), 32'h0);
	endtask
	task line_chk(input logic [9:0] v, input int e, input logic [1:0] st);
		u_dsp.line(v);
		rd(OFS_STATUS);
		cmp(rdat, 32'({st, 6'h0, v}));
		rd(OFS_DAC);
		cmp(rdat, 32'(e[15:0]));
		cmp(32'(dac), 32'(e[15:0]));
	endtask
	task t_loop;
		int n, k, ed;
		wr(OFS_CLAMP, 32'h20);
		ed = 0;
		for (n = 0; n < 4; n++)
		begin
			wr(OFS_LOOP, 32'(((n + 1) << 8) | (n << 2) | n));
			ed -= 40 << (2 + n);
			line_chk(10'd72, ed, 2'b01);
			ed += 8 << (2 + n);
			line_chk(10'd24, ed, 2'b10);
			for (k = 1; k <= (1 << n); k++)
				line_chk(10'd32, ed, {k < (1 << n), 1'b0});
		end
		ed -= 10;
		line_chk(10'd42, ed, 2'b00);
		cmp(32'(gain), 32'h4);
	endtask
	initial
	begin
		#100us;
		fail_count++;
		conclude();
	end
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_format();
		t_preblank();
		t_float();
		t_loop();
		conclude();
	end
endmodule
